// ### hdl/supply_monitor_trim_config.sv
/*
 * supply monitor and oscillator trim configuration bank.
 * holds the main-supply and battery trip selections, the battery
 * disconnect control, the stamp clear pulse and the read-only trim,
 * and derives a trimmed oscillator tick from the 40 MHz reference.
 * assumes the serial front end presents single-cycle byte reads and
 * writes on ref_clk, and that comparator and power-good levels arrive
 * asynchronously from the analog section.
 */
`timescale 1ns/10ps

module supply_monitor_trim_config (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       temp_sense_enable,
    input  wire logic [5:0] seconds_count,
    input  wire logic       main_supply_good,
    input  wire logic       main_below_trip,
    input  wire logic [1:0] factory_coarse_trim,
    input  wire logic [5:0] factory_fine_trim,
    output logic [7:0]      reg_rdata,
    output logic            clear_stamps,
    output logic [2:0]      main_supply_trip_sel,
    output logic            main_supply_low_flag,
    output logic [2:0]      first_battery_trip_sel,
    output logic [2:0]      second_battery_trip_sel,
    output logic            battery_disconnect,
    output logic            battery_check,
    output logic [1:0]      coarse_digital_trim,
    output logic [5:0]      fine_analog_trim,
    output logic            osc_tick
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [1:0] main_good_sync_q;
    logic [1:0] main_below_sync_q;
    logic [1:0] tse_sync_q;
    logic       tse_prev_q;
    logic       main_good_prev_q;

    // analog levels cross into ref_clk through two flops each; the power-good
    // chain resets to its idle high level, otherwise the release of reset
    // would look like a power return and wipe a disconnect written at once
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            main_good_sync_q  <= '1;
            main_below_sync_q <= 2'h0;
            tse_sync_q        <= 2'h0;
        end else begin
            main_good_sync_q  <= {main_good_sync_q[0], main_supply_good};
            main_below_sync_q <= {main_below_sync_q[0], main_below_trip};
            tse_sync_q        <= {tse_sync_q[0], temp_sense_enable};
        end
    end

    // edge history looks only at the second stage
    // history starts at each pin's idle level so no false edge follows reset
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tse_prev_q       <= 1'b0;
            main_good_prev_q <= 1'b1;
        end else begin
            tse_prev_q       <= tse_sync_q[1];
            main_good_prev_q <= main_good_sync_q[1];
        end
    end

    logic tse_rise;
    logic main_return;
    assign tse_rise    = tse_sync_q[1] & ~tse_prev_q;
    assign main_return = main_good_sync_q[1] & ~main_good_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // write decode

    // one strobe selects at most one register, so a misdirected address
    // never touches the bank
    logic wr_main;
    logic wr_batt;
    always_comb begin
        wr_main = 1'b0;
        wr_batt = 1'b0;
        if (reg_wr && reg_addr == supply_trim_pkg::MAIN_SUPPLY_CONTROL_ADDR) begin
            wr_main = 1'b1;
        end else if (reg_wr && reg_addr == supply_trim_pkg::BATTERY_TRIP_CONTROL_ADDR) begin
            wr_batt = 1'b1;
        end
        // writes to the trim address fall through: the trim is read-only
    end

    // clamp a three-bit trip code to the highest defined level
    function automatic logic [2:0] clamp_trip(input logic [2:0] code,
                                              input logic [2:0] max_code);
        clamp_trip = (code > max_code) ? max_code : code;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // main supply control

    logic [2:0] main_trip_q;
    logic       clear_stamps_q;

    // the clear bit never stores: it fires one pulse and reads back zero
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            clear_stamps_q <= 1'b0;
        end else begin
            clear_stamps_q <= wr_main & reg_wdata[supply_trim_pkg::CLEAR_STAMPS_BIT];
        end
    end

    // undefined codes from a misbehaving host are clamped so the comparator
    // always sees a real level rather than floating
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            main_trip_q <= supply_trim_pkg::TRIP_SEL_RESET;
        end else if (wr_main) begin
            main_trip_q <= clamp_trip(reg_wdata[supply_trim_pkg::MAIN_TRIP_LSB +: 3],
                                      supply_trim_pkg::MAIN_TRIP_MAX);
        end
    end

    // low flag follows the comparator against the selected level
    logic main_low_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            main_low_q <= 1'b0;
        end else begin
            main_low_q <= main_below_sync_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // battery trip control

    logic [2:0] first_trip_q;
    logic [2:0] second_trip_q;
    logic       disconnect_q;

    // both selections are written together but stored apart
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            first_trip_q  <= supply_trim_pkg::TRIP_SEL_RESET;
            second_trip_q <= supply_trim_pkg::TRIP_SEL_RESET;
        end else if (wr_batt) begin
            first_trip_q  <= clamp_trip(reg_wdata[supply_trim_pkg::FIRST_TRIP_LSB +: 3],
                                        supply_trim_pkg::BATTERY_TRIP_MAX);
            second_trip_q <= clamp_trip(reg_wdata[supply_trim_pkg::SECOND_TRIP_LSB +: 3],
                                        supply_trim_pkg::BATTERY_TRIP_MAX);
        end
    end

    // power return wins over a write in the same cycle, so the battery is
    // never left isolated once the main supply is back
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            disconnect_q <= 1'b0;
        end else if (main_return) begin
            disconnect_q <= 1'b0;
        end else if (wr_batt) begin
            disconnect_q <= reg_wdata[supply_trim_pkg::BATTERY_DISCONNECT_BIT];
        end
    end

    // battery check: once a minute on entering second 59, or on enable rising;
    // history resets to 59 so a reset released at second 59 adds no check
    logic       check_q;
    logic [5:0] seconds_prev_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            check_q        <= 1'b0;
            seconds_prev_q <= supply_trim_pkg::BATTERY_CHECK_SECOND;
        end else begin
            seconds_prev_q <= seconds_count;
            check_q        <= tse_rise
                | (seconds_count == supply_trim_pkg::BATTERY_CHECK_SECOND
                   && seconds_prev_q != supply_trim_pkg::BATTERY_CHECK_SECOND);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trim register

    logic [1:0] coarse_q;
    logic [5:0] fine_q;
    logic       loaded_q;

    // factory values are recalled once, the first cycle after reset;
    // nothing on the register port reaches these flops
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            coarse_q <= supply_trim_pkg::COARSE_TRIM_DEFAULT;
            fine_q   <= supply_trim_pkg::FINE_TRIM_DEFAULT;
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            coarse_q <= factory_coarse_trim;
            fine_q   <= factory_fine_trim;
            loaded_q <= 1'b1;
        end
    end

    // coarse trim seen by the pulse logic only updates while temperature
    // sensing is off, so a mid-run recall cannot jolt compensation
    logic [1:0] coarse_live_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            coarse_live_q <= supply_trim_pkg::COARSE_TRIM_DEFAULT;
        end else if (!tse_sync_q[1]) begin
            coarse_live_q <= coarse_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trimmed oscillator tick

    logic [25:0] phase_q;
    logic        raw_tick;
    logic [14:0] slot_q;
    logic        slot_end;
    logic        tick_q;

    assign raw_tick = (phase_q + supply_trim_pkg::OSC_STEP) >= supply_trim_pkg::OSC_MOD;
    assign slot_end = slot_q == supply_trim_pkg::TRIM_SLOT_TICKS;

    // fractional accumulator gives the nominal 32.768 kHz rate
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            phase_q <= 26'h0;
        end else if (raw_tick) begin
            phase_q <= phase_q + supply_trim_pkg::OSC_STEP - supply_trim_pkg::OSC_MOD;
        end else begin
            phase_q <= phase_q + supply_trim_pkg::OSC_STEP;
        end
    end

    // one pulse in 32768 is inserted or skipped, 30.5 ppm per step; the
    // analog part of the span is carried by the load code output
    // limitation: a slot lasts about one second of ticks, so the coarse step
    // only shows in measurements that span several slots
    logic insert_pending_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            slot_q           <= 15'h0;
            insert_pending_q <= 1'b0;
            tick_q           <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (insert_pending_q && !raw_tick) begin
                tick_q           <= 1'b1;
                insert_pending_q <= 1'b0;
            end else if (raw_tick) begin
                slot_q <= slot_end ? 15'h0 : slot_q + 15'h1;
                if (slot_end && coarse_live_q == supply_trim_pkg::TRIM_MINUS) begin
                    tick_q <= 1'b0;
                end else begin
                    tick_q <= 1'b1;
                end
                if (slot_end && coarse_live_q == supply_trim_pkg::TRIM_PLUS) begin
                    insert_pending_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data

    // read data is registered on the strobe and held until the next read;
    // the clear bit reads zero since it is only a pulse, and unmapped
    // addresses read zero so a probing host sees no stale byte
    logic [7:0] rdata_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == supply_trim_pkg::MAIN_SUPPLY_CONTROL_ADDR) begin
                rdata_q <= {5'h00, main_trip_q};
            end else if (reg_addr == supply_trim_pkg::BATTERY_TRIP_CONTROL_ADDR) begin
                rdata_q <= {1'b0, disconnect_q, first_trip_q, second_trip_q};
            end else if (reg_addr == supply_trim_pkg::INITIAL_TRIM_SETTING_ADDR) begin
                rdata_q <= {coarse_q, fine_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // every output is taken straight from its flop
    assign reg_rdata               = rdata_q;
    assign clear_stamps            = clear_stamps_q;
    assign main_supply_trip_sel    = main_trip_q;
    assign main_supply_low_flag    = main_low_q;
    assign first_battery_trip_sel  = first_trip_q;
    assign second_battery_trip_sel = second_trip_q;
    assign battery_disconnect      = disconnect_q;
    assign battery_check           = check_q;
    assign coarse_digital_trim     = coarse_live_q;
    assign fine_analog_trim        = fine_q;
    assign osc_tick                = tick_q;

endmodule

// ### hdl/supply_trim_pkg.sv
/*
 * constants for the supply monitor and trim configuration bank:
 * register offsets, field positions, trip codes, trim codes and timing.
 * assumes a single 40 MHz clock and a byte-wide register port driven by
 * the serial interface logic that sits in front of this bank.
 */
//
// Function
// - writing one to the clear-stamps bit clears both switchover stamp sets, bit resets to zero.
// - main-supply trip codes 000 to 101 select brownout levels 2.295 V up to 4.675 V.
// - a main supply below the selected threshold sets the main-supply-low flag.
// - the battery trip register holds two independent threshold selections, 85 and 75 percent.
// - the first battery selector offers seven codes from 2.125 V to 4.675 V.
// - the second battery selector offers seven codes from 1.875 V to 4.125 V.
// - writing one to the battery-disconnect bit starts isolating the backup battery.
// - when main supply returns after a power cycle the disconnect bit clears and battery reconnects.
// - factory trim values load at power-up and user writes to them are ignored.
// - digital trim skips or inserts pulses, analog trim steers load capacitance.
// - coarse digital trim decodes 00 off, 01 plus 30.5 ppm, 10 zero, 11 minus 30.5 ppm.
// - combined trimming spans plus 62.5 ppm down to minus 61.5 ppm.
// - setting temperature-sense enable triggers an immediate battery check besides second 59.
package supply_trim_pkg;

    // register offsets on the byte port
    localparam logic [7:0] MAIN_SUPPLY_CONTROL_ADDR  = 8'h09;
    localparam logic [7:0] BATTERY_TRIP_CONTROL_ADDR = 8'h0A;
    localparam logic [7:0] INITIAL_TRIM_SETTING_ADDR = 8'h0B;

    // field positions
    localparam int CLEAR_STAMPS_BIT       = 7;
    localparam int MAIN_TRIP_LSB          = 0;
    localparam int BATTERY_DISCONNECT_BIT = 6;
    localparam int FIRST_TRIP_LSB         = 3;
    localparam int SECOND_TRIP_LSB        = 0;
    localparam int COARSE_TRIM_LSB        = 6;
    localparam int FINE_TRIM_LSB          = 0;

    // reset values
    localparam logic [2:0] TRIP_SEL_RESET     = 3'h0;
    localparam logic [1:0] COARSE_TRIM_DEFAULT = 2'h2;
    localparam logic [5:0] FINE_TRIM_DEFAULT   = 6'h20;

    // highest legal trip codes
    localparam logic [2:0] MAIN_TRIP_MAX    = 3'h5;
    localparam logic [2:0] BATTERY_TRIP_MAX = 3'h6;

    // trip levels in millivolts, indexed by code
    localparam logic [12:0] MAIN_TRIP_MV [0:5] = '{
        13'h8F7, 13'h9F6, 13'hAF5, 13'hBF4, 13'h109A, 13'h1243};
    localparam logic [12:0] FIRST_TRIP_MV [0:6] = '{
        13'h84D, 13'h8F7, 13'h9F6, 13'hAF5, 13'hBF4, 13'h109A, 13'h1243};
    localparam logic [12:0] SECOND_TRIP_MV [0:6] = '{
        13'h753, 13'h7E9, 13'h8CA, 13'h9AB, 13'hA8C, 13'hEA6, 13'h101D};

    // coarse digital trim codes
    typedef enum logic [1:0] {
        TRIM_OFF   = 2'b00,
        TRIM_PLUS  = 2'b01,
        TRIM_ZERO  = 2'b10,
        TRIM_MINUS = 2'b11
    } coarse_trim_t;

    // oscillator tick: 32.768 kHz from 40 MHz, fractional accumulator
    localparam int unsigned REF_CLK_HZ = 32'h0262_5A00;
    localparam int unsigned OSC_HZ     = 32'h0000_8000;
    localparam logic [25:0] OSC_STEP   = 26'(OSC_HZ);
    localparam logic [25:0] OSC_MOD    = 26'(REF_CLK_HZ);

    // pulses per adjustment slot: 30.5 ppm is one pulse in 32768 ticks
    localparam logic [14:0] TRIM_SLOT_TICKS = 15'h7FFF;

    // analog load code maps +32 (0x00) to -31 (0x3F) in 1 ppm steps
    localparam logic [5:0] ANALOG_MAX_CODE = 6'h3F;

    // second value that triggers the periodic battery check
    localparam logic [5:0] BATTERY_CHECK_SECOND = 6'h3B;

endpackage

// ### tb/serial_host_model.sv
/*
 * host side of the byte register port: one-cycle read and write strobes.
 * assumes the bank takes a request at the edge that sees the strobe and
 * presents read data one cycle later.
 */
`timescale 1ns/10ps
module serial_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata
);
    // idle port from time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // trip codes above the table are sent only when a clamp to the highest code is wanted
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
    endtask

    // data is taken one edge after the strobe, when it has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule

// ### tb/supply_monitor_trim_config_test.sv
/*
 * self-checking bench for the supply trim bank.
 * assumes the host model for register traffic and drives the analog
 * levels, seconds value and factory trim itself, 1 ns after each edge.
 */
`timescale 1ns/10ps
module supply_monitor_trim_config_test;
    localparam logic [1:0] FAC_COARSE = 2'h1;
    localparam logic [5:0] FAC_FINE   = 6'h15;
    logic       ref_clk, rstn, temp_sense_enable, main_supply_good, main_below_trip;
    logic       reg_wr, reg_rd, clear_stamps, main_supply_low_flag, battery_disconnect;
    logic       battery_check, osc_tick;
    logic [5:0] seconds_count, fine_analog_trim;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v, ev;
    logic [2:0] main_supply_trip_sel, first_battery_trip_sel, second_battery_trip_sel;
    logic [1:0] coarse_digital_trim;
    int         err_total, total_checks, n;

    supply_monitor_trim_config dut (.ref_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .temp_sense_enable, .seconds_count, .main_supply_good, .main_below_trip,
        .factory_coarse_trim(FAC_COARSE), .factory_fine_trim(FAC_FINE), .reg_rdata,
        .clear_stamps, .main_supply_trip_sel, .main_supply_low_flag, .first_battery_trip_sel,
        .second_battery_trip_sel, .battery_disconnect, .battery_check, .coarse_digital_trim,
        .fine_analog_trim, .osc_tick);
    serial_host_model host (.ref_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

    // 40 MHz reference
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    // bounded wait; a miss is counted and ends the run
    task automatic wait_for(ref logic s, input logic v);
        int k = 0;
        while (s !== v && k < 10) begin
            cyc(1);
            k++;
        end
        check({7'h0, s}, {7'h0, v});
        if (s !== v) test_done();
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        err_total = 0;
        total_checks = 0;
        rstn = 1'b0;
        temp_sense_enable = 1'b0;
        seconds_count = 6'h00;
        main_supply_good = 1'b1;
        main_below_trip = 1'b0;
        cyc(3);
        rstn = 1'b1;
        cyc(2);
        host.rd(8'h09, rd_v);
        check(rd_v, 8'h00);
        host.rd(8'h0B, rd_v);
        check(rd_v, {FAC_COARSE, FAC_FINE});
        check({6'h0, coarse_digital_trim}, {6'h0, FAC_COARSE});
        check({2'h0, fine_analog_trim}, {2'h0, FAC_FINE});
        for (int i = 0; i < 6; i++) begin
            host.wr(8'h09, 8'(i));
            host.rd(8'h09, rd_v);
            check(rd_v, 8'(i));
        end
        host.wr(8'h09, 8'h83);
        check({7'h0, clear_stamps}, 8'h01);
        cyc(1);
        check({7'h0, clear_stamps}, 8'h00);
        host.rd(8'h09, rd_v);
        check(rd_v, 8'h03);
        host.wr(8'h09, 8'h07);
        check({5'h0, main_supply_trip_sel}, 8'h05);
        for (int i = 0; i < 7; i++) begin
            ev = 8'((i << 3) | (6 - i));
            host.wr(8'h0A, ev);
            check({2'h0, first_battery_trip_sel, second_battery_trip_sel}, ev);
            host.rd(8'h0A, rd_v);
            check(rd_v, ev);
        end
        host.wr(8'h0A, 8'h3F);
        check({2'h0, first_battery_trip_sel, second_battery_trip_sel}, 8'h36);
        host.wr(8'h0A, 8'h40);
        check({7'h0, battery_disconnect}, 8'h01);
        host.rd(8'h0A, rd_v);
        check(rd_v, 8'h40);
        main_supply_good = 1'b0;
        cyc(4);
        main_supply_good = 1'b1;
        wait_for(battery_disconnect, 1'b0);
        host.wr(8'h0B, 8'hFF);
        host.rd(8'h0B, rd_v);
        check(rd_v, {FAC_COARSE, FAC_FINE});
        check({2'h0, fine_analog_trim}, {2'h0, FAC_FINE});
        host.wr(8'h0C, 8'h55);
        host.rd(8'h0C, rd_v);
        check(rd_v, 8'h00);
        check({7'h0, main_supply_low_flag}, 8'h00);
        main_below_trip = 1'b1;
        cyc(6);
        check({7'h0, main_supply_low_flag}, 8'h01);
        seconds_count = 6'h3A;
        cyc(2);
        seconds_count = 6'h3B;
        cyc(1);
        check({7'h0, battery_check}, 8'h01);
        cyc(1);
        check({7'h0, battery_check}, 8'h00);
        temp_sense_enable = 1'b1;
        wait_for(battery_check, 1'b1);
        check({6'h0, coarse_digital_trim}, {6'h0, FAC_COARSE});
        temp_sense_enable = 1'b0;
        // roughly ten oscillator ticks fit in this window
        n = 0;
        repeat (12208) begin
            cyc(1);
            if (osc_tick === 1'b1) n++;
        end
        check(8'(n >= 9 && n <= 11), 8'h01);
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        cyc(1);
        check({7'h0, battery_check}, 8'h00);
        host.wr(8'h0A, 8'h40);
        check({7'h0, battery_disconnect}, 8'h01);
        host.rd(8'h09, rd_v);
        check(rd_v, 8'h00);
        test_done();
    end
endmodule

// ### tb/supply_trim_props.sv
/*
 * port checker for the supply trim bank.
 * assumes one clock, a synchronous active-low reset and a host that
 * does not read and write in the same cycle.
 */
`timescale 1ns/10ps
module supply_trim_props (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [5:0] seconds_count,
    input wire logic       main_supply_good,
    input wire logic       main_below_trip,
    input wire logic [7:0] reg_rdata,
    input wire logic       clear_stamps,
    input wire logic [2:0] main_supply_trip_sel,
    input wire logic       main_supply_low_flag,
    input wire logic [2:0] first_battery_trip_sel,
    input wire logic [2:0] second_battery_trip_sel,
    input wire logic       battery_disconnect,
    input wire logic       battery_check,
    input wire logic [5:0] fine_analog_trim
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // accepted writes, one per register
    sequence wr_main_s;
        reg_wr && reg_addr == 8'h09;
    endsequence
    sequence wr_bat_s;
        reg_wr && reg_addr == 8'h0A;
    endsequence

    ////////////////////////////////////////////////////////////////
    a_clear_on_write: assert property (wr_main_s ##0 reg_wdata[7] |=> clear_stamps)
        else $error("clear pulse missing after write");
    a_clear_has_cause: assert property (clear_stamps |-> $past(reg_wr)
        && $past(reg_addr) == 8'h09 && $past(reg_wdata[7])) else $error("stray clear pulse");
    a_main_trip_code: assert property (wr_main_s ##0 reg_wdata[2:0] <= 3'h5
        |=> main_supply_trip_sel == $past(reg_wdata[2:0])) else $error("main trip not stored");
    a_bat_trip_codes: assert property (wr_bat_s ##0 (reg_wdata[5:3] <= 3'h6
        && reg_wdata[2:0] <= 3'h6) |=> first_battery_trip_sel == $past(reg_wdata[5:3])
        && second_battery_trip_sel == $past(reg_wdata[2:0])) else $error("battery trips wrong");
    // a power return in flight would rightly win, so demand a settled supply
    a_disconnect_set: assert property (main_supply_good[*5] ##0 wr_bat_s ##0 reg_wdata[6]
        |=> battery_disconnect) else $error("disconnect not set");
    a_power_reconnect: assert property ($rose(main_supply_good) |-> ##[1:4] !battery_disconnect)
        else $error("disconnect not cleared on power return");
    a_low_flag_follow: assert property (main_below_trip[*5] |-> main_supply_low_flag)
        else $error("low flag missing");
    a_trim_write_lock: assert property (reg_wr && reg_addr == 8'h0B && $past(rstn)
        |=> $stable(fine_analog_trim)) else $error("trim changed by a write");
    a_check_at_59: assert property (seconds_count == 6'h3B && $past(seconds_count) != 6'h3B
        |=> battery_check) else $error("no battery check at second 59");
    a_read_main_reg: assert property (reg_rd && !reg_wr && reg_addr == 8'h09
        |=> reg_rdata == {5'h00, main_supply_trip_sel}) else $error("main register read wrong");
endmodule

bind supply_monitor_trim_config supply_trim_props chk (.ref_clk, .rstn, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .seconds_count, .main_supply_good, .main_below_trip, .reg_rdata,
    .clear_stamps, .main_supply_trip_sel, .main_supply_low_flag, .first_battery_trip_sel,
    .second_battery_trip_sel, .battery_disconnect, .battery_check, .fine_analog_trim);
